// ==== logic/sir_routing_pkg.sv ====
// Constants, types and register layout for the infrared pin routing block
package sir_routing_pkg;
	// Register byte offsets on the configuration bus
	localparam logic [3:0] FUNC_CTRL_OFFSET  = 4'h0;
	localparam logic [3:0] IR_CFG_OFFSET     = 4'h4;
	localparam logic [3:0] PORT_MODE_OFFSET  = 4'h8;
	localparam logic [3:0] PIN_STATUS_OFFSET = 4'hc;
	localparam int         ADDR_W            = 4;

	// Field positions
	localparam int CTRL_PD_SEL_BIT     = 6;
	localparam int IR_EN_BIT           = 0;
	localparam int IR_PLACE_LSB        = 2;
	localparam int PM_EPP_BIT          = 0;
	localparam int PM_FLOPPY_BIT       = 1;
	localparam int PM_FLOPPY_FLAG_BIT  = 2;

	// Values after reset
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] IR_RESET   = 8'h00;
	localparam logic [7:0] PM_RESET   = 8'h00;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Infrared placement, in field order 00, 01, 10, 11
	typedef enum logic [1:0] {
		LOC_NONE,
		LOC_PORT2,
		LOC_DRIVE_TX,
		LOC_DRIVE_ALL
	} ir_location_t;

	// Modem status lines of the second serial port
	typedef struct packed {
		logic ring;
		logic cts;
		logic dcd;
		logic dsr;
	} modem_lines_t;

	// Software configuration as seen by the routing logic
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] ir;
		logic [7:0] pmode;
	} config_t;
endpackage

// ==== logic/cfg_bus_slave.sv ====
// AXI4-Lite slave holding the routing configuration registers
`timescale 1ns/1ps
module cfg_bus_slave (
	input  wire logic                          clk_in,
	input  wire logic                          rst_n_in,
	input  wire logic [sir_routing_pkg::ADDR_W-1:0] awaddr_in,
	input  wire logic                          awvalid_in,
	output logic                               awready_out,
	input  wire logic [31:0]                   wdata_in,
	input  wire logic [3:0]                    wstrb_in,
	input  wire logic                          wvalid_in,
	output logic                               wready_out,
	output logic [1:0]                         bresp_out,
	output logic                               bvalid_out,
	input  wire logic                          bready_in,
	input  wire logic [sir_routing_pkg::ADDR_W-1:0] araddr_in,
	input  wire logic                          arvalid_in,
	output logic                               arready_out,
	output logic [31:0]                        rdata_out,
	output logic [1:0]                         rresp_out,
	output logic                               rvalid_out,
	input  wire logic                          rready_in,
	input  wire logic [7:0]                    status_in,
	output sir_routing_pkg::config_t           cfg_out
);
	import sir_routing_pkg::*;

	logic                 aw_q, aw_d;
	logic                 ar_q, ar_d;
	logic                 bv_q, bv_d;
	logic                 rv_q, rv_d;
	logic [1:0]           br_q, br_d;
	logic [1:0]           rr_q, rr_d;
	logic [31:0]          rd_q, rd_d;
	config_t              cfg_q, cfg_d;
	logic                 wr_go, rd_go;

	// Next state of handshakes and registers
	always_comb begin
		wr_go = awvalid_in && wvalid_in && !bv_q && !aw_q;
		rd_go = arvalid_in && !rv_q && !ar_q;
		aw_d  = wr_go;
		ar_d  = rd_go;
		cfg_d = cfg_q;
		br_d  = br_q;
		bv_d  = bv_q && !bready_in;
		rv_d  = rv_q && !rready_in;
		rr_d  = rr_q;
		rd_d  = rd_q;
		// Answer only once both write channels have been taken
		if (aw_q)
			bv_d = 1'b1;
		if (wr_go) begin
			br_d = RESP_OKAY;
			unique case (awaddr_in)
				FUNC_CTRL_OFFSET: if (wstrb_in[0]) cfg_d.ctrl = wdata_in[7:0];
				IR_CFG_OFFSET:    if (wstrb_in[0]) cfg_d.ir = wdata_in[7:0];
				PORT_MODE_OFFSET: if (wstrb_in[0]) cfg_d.pmode = wdata_in[7:0];
				PIN_STATUS_OFFSET: br_d = RESP_OKAY; // Read-only
				default: br_d = RESP_SLVERR;
			endcase
		end
		// Read data follow the address handshake by one cycle
		if (ar_q)
			rv_d = 1'b1;
		if (rd_go) begin
			rr_d = RESP_OKAY;
			rd_d = 32'h0;
			unique case (araddr_in)
				FUNC_CTRL_OFFSET:  rd_d[7:0] = cfg_q.ctrl;
				IR_CFG_OFFSET:     rd_d[7:0] = cfg_q.ir;
				PORT_MODE_OFFSET:  rd_d[7:0] = cfg_q.pmode;
				PIN_STATUS_OFFSET: rd_d[7:0] = status_in;
				default:           rr_d = RESP_SLVERR;
			endcase
		end
	end

	// Register stage
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			aw_q  <= 1'b0;
			ar_q  <= 1'b0;
			bv_q  <= 1'b0;
			rv_q  <= 1'b0;
			br_q  <= RESP_OKAY;
			rr_q  <= RESP_OKAY;
			rd_q  <= 32'h0;
			cfg_q <= '{ctrl: CTRL_RESET, ir: IR_RESET, pmode: PM_RESET};
		end else begin
			aw_q  <= aw_d;
			ar_q  <= ar_d;
			bv_q  <= bv_d;
			rv_q  <= rv_d;
			br_q  <= br_d;
			rr_q  <= rr_d;
			rd_q  <= rd_d;
			cfg_q <= cfg_d;
		end
	end

	assign awready_out = aw_q;
	assign wready_out  = aw_q;
	assign arready_out = ar_q;
	assign bvalid_out  = bv_q;
	assign bresp_out   = br_q;
	assign rvalid_out  = rv_q;
	assign rresp_out   = rr_q;
	assign rdata_out   = rd_q;
	assign cfg_out     = cfg_q;
endmodule

// ==== logic/sir_pin_routing.sv ====
// Infrared pin routing, shared wait/power-down pin and parallel port pins
//
// Contract
// - With control bit 6 clear the shared pin is an open-drain wait output.
// - The wait output pulls low on a shortenable enhanced-port write.
// - With control bit 6 set the shared pin is the active-low power-down.
// - In port-floppy mode with the port flag 0 a port pin is write protect.
// - In enhanced mode the strobe pin is an active-low write strobe.
// - Placement 11 ignores every other infrared configuration bit.
// - In placement 11 the drive ident and 16-bit select are undefined.
// - Receive on the acknowledge pin forces internal acknowledge to 1.
// - Infrared mode holds the serial output high but not the baud clock.
// - The forced-zero set-ready applies to the internal input only.
`timescale 1ns/1ps
module sir_pin_routing (
	input  wire logic                          clk_in,
	input  wire logic                          rst_n_in,
	input  wire logic [sir_routing_pkg::ADDR_W-1:0] awaddr_in,
	input  wire logic                          awvalid_in,
	output logic                               awready_out,
	input  wire logic [31:0]                   wdata_in,
	input  wire logic [3:0]                    wstrb_in,
	input  wire logic                          wvalid_in,
	output logic                               wready_out,
	output logic [1:0]                         bresp_out,
	output logic                               bvalid_out,
	input  wire logic                          bready_in,
	input  wire logic [sir_routing_pkg::ADDR_W-1:0] araddr_in,
	input  wire logic                          arvalid_in,
	output logic                               arready_out,
	output logic [31:0]                        rdata_out,
	output logic [1:0]                         rresp_out,
	output logic                               rvalid_out,
	input  wire logic                          rready_in,
	input  wire logic                          wait_pwr_pin_in,
	input  wire logic                          epp_write_in,
	input  wire logic                          cycle_short_ok_in,
	output logic                               zero_wait_out,
	output logic                               zero_wait_oe_out,
	output logic                               power_down_n_out,
	input  wire logic                          epp_strobe_req_in,
	input  wire logic                          spp_strobe_n_in,
	output logic                               strobe_pin_n_out,
	input  wire logic                          floppy_wp_pin_in,
	output logic                               floppy_wp_extra_out,
	input  wire logic                          port2_serial_output_in,
	input  wire logic                          port2_baud_clock_out_in,
	input  wire logic                          port2_baud_sel_in,
	output logic                               port2_tx_pin_out,
	input  wire logic                          port2_terminal_ready_in,
	output logic                               port2_terminal_pin_out,
	input  sir_routing_pkg::modem_lines_t      port2_modem_pins_in,
	output sir_routing_pkg::modem_lines_t      port2_modem_int_out,
	input  wire logic                          ir_encoder_tx_in,
	output logic                               ir_decoder_rx_out,
	input  wire logic                          drive_high_byte_enable_in,
	output logic                               drive_high_byte_pin_out,
	input  wire logic                          drive_ack_pin_in,
	output logic                               drive_dma_acknowledge_out,
	input  wire logic [1:0]                    drive_ident_pins_in,
	input  wire logic                          drive_16bit_pin_in,
	output logic [1:0]                         drive_ident_out,
	output logic                               drive_16bit_select_out,
	output logic                               drive_status_valid_out
);
	import sir_routing_pkg::*;

	config_t      cfg;
	logic [7:0]   status;
	ir_location_t loc;
	logic         sir_on;
	logic         pd_sel;

	// Placement field decode
	function automatic ir_location_t loc_of(input logic [7:0] cfg_byte);
		return ir_location_t'(cfg_byte[IR_PLACE_LSB +: 2]);
	endfunction

	// Infrared active: placement 11 overrides the enable bit
	function automatic logic sir_of(input logic [7:0] cfg_byte);
		return (loc_of(cfg_byte) == LOC_DRIVE_ALL) ||
		       (loc_of(cfg_byte) != LOC_NONE && cfg_byte[IR_EN_BIT]);
	endfunction

	// Configuration registers
	cfg_bus_slave u_regs (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n_in),
		.awaddr_in   (awaddr_in),
		.awvalid_in  (awvalid_in),
		.awready_out (awready_out),
		.wdata_in    (wdata_in),
		.wstrb_in    (wstrb_in),
		.wvalid_in   (wvalid_in),
		.wready_out  (wready_out),
		.bresp_out   (bresp_out),
		.bvalid_out  (bvalid_out),
		.bready_in   (bready_in),
		.araddr_in   (araddr_in),
		.arvalid_in  (arvalid_in),
		.arready_out (arready_out),
		.rdata_out   (rdata_out),
		.rresp_out   (rresp_out),
		.rvalid_out  (rvalid_out),
		.rready_in   (rready_in),
		.status_in   (status),
		.cfg_out     (cfg)
	);

	assign loc      = loc_of(cfg.ir);
	assign sir_on   = sir_of(cfg.ir);
	assign pd_sel   = cfg.ctrl[CTRL_PD_SEL_BIT];

	logic         zw_oe_q, zw_oe_d;
	logic         pd_n_q, pd_n_d;
	logic         stb_q, stb_d;
	logic         wp_q, wp_d;
	logic         tx2_q, tx2_d;
	logic         dtr_q, dtr_d;
	modem_lines_t mdm_q, mdm_d;
	logic         rx_q, rx_d;
	logic         hi_q, hi_d;
	logic         ack_q, ack_d;
	logic [1:0]   id_q, id_d;
	logic         cs16_q, cs16_d;
	logic         dv_q, dv_d;

	// Next values of every routed pin
	always_comb begin
		// Shared pin: wait output or power-down input
		zw_oe_d = !pd_sel && epp_write_in && cycle_short_ok_in;
		pd_n_d  = pd_sel ? wait_pwr_pin_in : 1'b1;
		// Parallel port strobe and extra write protect
		stb_d = cfg.pmode[PM_EPP_BIT] ? !epp_strobe_req_in
		                              : spp_strobe_n_in;
		wp_d  = cfg.pmode[PM_FLOPPY_BIT] && !cfg.pmode[PM_FLOPPY_FLAG_BIT] &&
		        floppy_wp_pin_in;
		// Second port serial output, baud clock passes untouched
		if (port2_baud_sel_in)
			tx2_d = port2_baud_clock_out_in;
		else
			tx2_d = sir_on ? 1'b1 : port2_serial_output_in;
		// Modem inputs pass through unless infrared or placement 01 forces them
		mdm_d = port2_modem_pins_in;
		if (sir_on) begin
			mdm_d.ring = 1'b1;
			mdm_d.cts  = 1'b0;
			mdm_d.dcd  = 1'b1;
			mdm_d.dsr  = 1'b0;
		end
		if (loc == LOC_PORT2)
			mdm_d.dsr = 1'b0;
		// Pin defaults are the normal functions
		dtr_d  = port2_terminal_ready_in;
		hi_d   = drive_high_byte_enable_in;
		ack_d  = drive_ack_pin_in;
		id_d   = drive_ident_pins_in;
		cs16_d = drive_16bit_pin_in;
		dv_d   = 1'b1;
		rx_d   = 1'b1;
		unique case (loc)
			LOC_NONE: begin
				dv_d = 1'b1;
			end
			LOC_PORT2: begin
				dtr_d = sir_on ? ir_encoder_tx_in : 1'b0;
				rx_d  = sir_on ? port2_modem_pins_in.dsr : 1'b1;
			end
			LOC_DRIVE_TX: begin
				hi_d = sir_on ? ir_encoder_tx_in : 1'b0;
			end
			LOC_DRIVE_ALL: begin
				hi_d   = ir_encoder_tx_in;
				rx_d   = drive_ack_pin_in;
				ack_d  = 1'b1;
				id_d   = 2'h0;
				cs16_d = 1'b0;
				dv_d   = 1'b0;
			end
		endcase
	end

	// Output registers
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			zw_oe_q <= 1'b0;
			pd_n_q  <= 1'b1;
			stb_q   <= 1'b1;
			wp_q    <= 1'b0;
			tx2_q   <= 1'b1;
			dtr_q   <= 1'b0;
			mdm_q   <= '{ring: 1'b0, cts: 1'b0, dcd: 1'b0, dsr: 1'b0};
			rx_q    <= 1'b1;
			hi_q    <= 1'b0;
			ack_q   <= 1'b1;
			id_q    <= 2'h0;
			cs16_q  <= 1'b0;
			dv_q    <= 1'b0;
		end else begin
			zw_oe_q <= zw_oe_d;
			pd_n_q  <= pd_n_d;
			stb_q   <= stb_d;
			wp_q    <= wp_d;
			tx2_q   <= tx2_d;
			dtr_q   <= dtr_d;
			mdm_q   <= mdm_d;
			rx_q    <= rx_d;
			hi_q    <= hi_d;
			ack_q   <= ack_d;
			id_q    <= id_d;
			cs16_q  <= cs16_d;
			dv_q    <= dv_d;
		end
	end

	// Open-drain: level is always low, enable does the pulling
	assign zero_wait_out             = 1'b0;
	assign zero_wait_oe_out          = zw_oe_q;
	assign power_down_n_out          = pd_n_q;
	assign strobe_pin_n_out          = stb_q;
	assign floppy_wp_extra_out       = wp_q;
	assign port2_tx_pin_out          = tx2_q;
	assign port2_terminal_pin_out    = dtr_q;
	assign port2_modem_int_out       = mdm_q;
	assign ir_decoder_rx_out         = rx_q;
	assign drive_high_byte_pin_out   = hi_q;
	assign drive_dma_acknowledge_out = ack_q;
	assign drive_ident_out           = id_q;
	assign drive_16bit_select_out    = cs16_q;
	assign drive_status_valid_out    = dv_q;

	// Readable pin state
	assign status = {2'h0, zw_oe_q, pd_n_q, dv_q, loc, sir_on};

	// Checks on the routed pins
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	a_wait_pull_low: assert property (
		!pd_sel && epp_write_in && cycle_short_ok_in |=> zero_wait_oe_out)
		else $error("wait pin not pulled on short write");
	a_wait_idle_pd: assert property (
		pd_sel |=> !zero_wait_oe_out)
		else $error("wait pin driven in power-down use");
	a_pd_follows_pin: assert property (
		pd_sel ##1 pd_sel |-> power_down_n_out == $past(wait_pwr_pin_in))
		else $error("power-down does not follow shared pin");
	a_wp_extra_pin: assert property (
		cfg.pmode[PM_FLOPPY_BIT] && !cfg.pmode[PM_FLOPPY_FLAG_BIT]
		|=> floppy_wp_extra_out == $past(floppy_wp_pin_in))
		else $error("extra write protect not sampled");
	a_wp_off_mode: assert property (
		!(cfg.pmode[PM_FLOPPY_BIT] && !cfg.pmode[PM_FLOPPY_FLAG_BIT])
		|=> !floppy_wp_extra_out)
		else $error("extra write protect outside floppy mode");
	a_epp_strobe: assert property (
		cfg.pmode[PM_EPP_BIT] && epp_strobe_req_in |=> !strobe_pin_n_out)
		else $error("write strobe not active low");
	a_spp_strobe: assert property (
		!cfg.pmode[PM_EPP_BIT] |=> strobe_pin_n_out == $past(spp_strobe_n_in))
		else $error("normal strobe not passed through");
	a_loc11_ignores: assert property (
		loc == LOC_DRIVE_ALL && !cfg.ir[IR_EN_BIT] ##1 loc == LOC_DRIVE_ALL
		|-> drive_high_byte_pin_out == $past(ir_encoder_tx_in)
		    && port2_tx_pin_out == 1'b1 || $past(port2_baud_sel_in))
		else $error("placement 11 obeys enable bit");
	a_ident_undefined: assert property (
		loc == LOC_DRIVE_ALL |=> !drive_status_valid_out)
		else $error("ident marked valid in placement 11");
	a_ack_forced_high: assert property (
		loc == LOC_DRIVE_ALL |=> drive_dma_acknowledge_out ##0
		ir_decoder_rx_out == $past(drive_ack_pin_in))
		else $error("acknowledge not held inactive");
	a_sout_forced_high: assert property (
		sir_on && !port2_baud_sel_in |=> port2_tx_pin_out)
		else $error("serial output not high in infrared mode");
	a_bout_not_forced: assert property (
		port2_baud_sel_in |=> port2_tx_pin_out == $past(port2_baud_clock_out_in))
		else $error("baud clock forced");
	a_dsr_internal_zero: assert property (
		loc == LOC_PORT2 && sir_on |=> !port2_modem_int_out.dsr
		&& ir_decoder_rx_out == $past(port2_modem_pins_in.dsr))
		else $error("set-ready forcing hit the receive path");
	a_port2_routing: assert property (
		loc == LOC_PORT2 && sir_on |=> port2_modem_int_out.ring
		&& !port2_modem_int_out.cts && port2_modem_int_out.dcd
		&& port2_terminal_pin_out == $past(ir_encoder_tx_in))
		else $error("placement 01 routing wrong");
	// Reset sampled low skips the edge whose outputs still hold reset values
	a_none_normal: assert property (
		rst_n_in && loc == LOC_NONE |=> port2_tx_pin_out ==
		($past(port2_baud_sel_in) ? $past(port2_baud_clock_out_in)
		: $past(port2_serial_output_in))
		&& drive_high_byte_pin_out == $past(drive_high_byte_enable_in)
		&& port2_modem_int_out == $past(port2_modem_pins_in))
		else $error("placement 00 disturbs pins");

	c_short_write: cover property (
		!pd_sel && epp_write_in && cycle_short_ok_in ##1 zero_wait_oe_out);
	c_port2_sir: cover property (loc == LOC_PORT2 && sir_on ##1 sir_on);
	c_drive_all: cover property (loc == LOC_DRIVE_ALL ##1 !drive_status_valid_out);
	c_power_down: cover property (pd_sel ##1 !power_down_n_out);
	c_loc11_bare: cover property (loc == LOC_DRIVE_ALL && !cfg.ir[IR_EN_BIT]);
endmodule

// ==== verif/ir_transceiver_model.sv ====
// Behavioural infrared transceiver facing the routing block
`timescale 1ns/1ps
module ir_transceiver_model (
	input  wire logic clk_in,
	input  wire logic send_in,
	input  wire logic tx_pin_in,
	output logic      rx_pin_out,
	output logic      tx_seen_out
);
	// Receive line shows the light level the bench asks for
	assign rx_pin_out = send_in;

	// Transmit pin as the emitter driver samples it
	always_ff @(posedge clk_in) begin
		tx_seen_out <= tx_pin_in;
	end
endmodule

// ==== verif/sir_pin_routing_tb.sv ====
// Self-checking bench for the infrared pin routing block
`timescale 1ns/1ps
module sir_pin_routing_tb;
	import sir_routing_pkg::*;
	logic              clk_in = 1'b0;
	logic              rst_n_in;
	logic [ADDR_W-1:0] awaddr_in, araddr_in;
	logic [31:0]       wdata_in, rdata_out;
	logic [3:0]        wstrb_in;
	logic [1:0]        bresp_out, rresp_out, cur_loc;
	logic awvalid_in, awready_out, wvalid_in, wready_out, bvalid_out;
	logic bready_in, arvalid_in, arready_out, rvalid_out, rready_in;
	logic wait_pwr_pin_in, epp_write_in, cycle_short_ok_in, zero_wait_out;
	logic zero_wait_oe_out, power_down_n_out, epp_strobe_req_in;
	logic spp_strobe_n_in, strobe_pin_n_out, floppy_wp_pin_in;
	logic floppy_wp_extra_out, port2_serial_output_in, port2_baud_sel_in;
	logic port2_baud_clock_out_in, port2_tx_pin_out, port2_terminal_ready_in;
	logic port2_terminal_pin_out, ir_encoder_tx_in, ir_decoder_rx_out;
	logic drive_high_byte_enable_in, drive_high_byte_pin_out;
	logic drive_ack_pin_in, drive_dma_acknowledge_out, drive_16bit_pin_in;
	logic drive_16bit_select_out, drive_status_valid_out;
	logic [1:0]        drive_ident_pins_in, drive_ident_out;
	modem_lines_t      port2_modem_pins_in, port2_modem_int_out;
	logic              ir_send, ir_line, ir_tx_line, tx_seen;
	int                n_fail = 0;
	int                checked = 0;
	int                cyc = 0;

	sir_pin_routing i_dut (
		.clk_in, .rst_n_in, .awaddr_in, .awvalid_in, .awready_out,
		.wdata_in, .wstrb_in, .wvalid_in, .wready_out, .bresp_out,
		.bvalid_out, .bready_in, .araddr_in, .arvalid_in, .arready_out,
		.rdata_out, .rresp_out, .rvalid_out, .rready_in, .wait_pwr_pin_in,
		.epp_write_in, .cycle_short_ok_in, .zero_wait_out, .zero_wait_oe_out,
		.power_down_n_out, .epp_strobe_req_in, .spp_strobe_n_in,
		.strobe_pin_n_out, .floppy_wp_pin_in, .floppy_wp_extra_out,
		.port2_serial_output_in, .port2_baud_clock_out_in, .port2_baud_sel_in,
		.port2_tx_pin_out, .port2_terminal_ready_in, .port2_terminal_pin_out,
		.port2_modem_pins_in, .port2_modem_int_out, .ir_encoder_tx_in,
		.ir_decoder_rx_out, .drive_high_byte_enable_in,
		.drive_high_byte_pin_out, .drive_ack_pin_in,
		.drive_dma_acknowledge_out, .drive_ident_pins_in, .drive_16bit_pin_in,
		.drive_ident_out, .drive_16bit_select_out, .drive_status_valid_out
	);

	ir_transceiver_model i_xcvr (
		.clk_in, .send_in(ir_send), .tx_pin_in(ir_tx_line),
		.rx_pin_out(ir_line), .tx_seen_out(tx_seen)
	);

	// Transceiver transmit wiring follows the chosen placement; its receive line feeds both the acknowledge and set-ready pins
	assign ir_tx_line = (cur_loc == 2'h1) ? port2_terminal_pin_out
		: drive_high_byte_pin_out;
	assign drive_ack_pin_in = ir_line;
	assign port2_modem_pins_in = {3'b010, ir_line};

	// Free-running clock
	always #20 clk_in = ~clk_in;

	// Cycle ceiling against a hung handshake
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			give_verdict();
		end
	end

	task give_verdict;
		if (n_fail == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Compare one value and count it
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Let the registered outputs follow the new inputs
	task automatic settle;
		repeat (2) @(posedge clk_in);
		#1;
	endtask

	task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
		output logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk_in);
		awaddr_in <= a;
		wdata_in <= {24'h0, d};
		awvalid_in <= 1'b1;
		wvalid_in <= 1'b1;
		bready_in <= 1'b1;
		// Each channel is released at the edge its own ready is seen
		while (!(aw_done && w_done)) begin
			@(posedge clk_in);
			if (awready_out === 1'b1) begin
				aw_done = 1'b1;
				awvalid_in <= 1'b0;
			end
			if (wready_out === 1'b1) begin
				w_done = 1'b1;
				wvalid_in <= 1'b0;
			end
		end
		while (bvalid_out !== 1'b1) @(posedge clk_in);
		r = bresp_out;
		bready_in <= 1'b0;
	endtask

	task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk_in);
		araddr_in <= a;
		arvalid_in <= 1'b1;
		rready_in <= 1'b1;
		do @(posedge clk_in); while (arready_out !== 1'b1);
		arvalid_in <= 1'b0;
		while (rvalid_out !== 1'b1) @(posedge clk_in);
		d = rdata_out;
		r = rresp_out;
		rready_in <= 1'b0;
	endtask

	// Register access, unmapped and read-only places
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		bus_wr(PORT_MODE_OFFSET, 8'h05, r);
		bus_rd(PORT_MODE_OFFSET, d, r);
		chk("pm_rd", d, 32'h5);
		bus_wr(4'h2, 8'hff, r);
		chk("bad_wr", r, RESP_SLVERR);
		bus_rd(4'h2, d, r);
		chk("bad_rd", {d[29:0], r}, {30'h0, RESP_SLVERR});
		bus_wr(PIN_STATUS_OFFSET, 8'hff, r);
		chk("st_wr", r, RESP_OKAY);
		bus_rd(PIN_STATUS_OFFSET, d, r);
		chk("st_rd", d, 32'h18);
		bus_wr(PORT_MODE_OFFSET, 8'h00, r);
	endtask

	// Shared pin as wait output, then as power-down input
	task automatic t_wait;
		logic [1:0] r;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in);
			epp_write_in <= i[0];
			cycle_short_ok_in <= i[1];
			settle();
			chk("zw_oe", zero_wait_oe_out, i == 3);
			chk("zw_lvl", zero_wait_out, 1'b0);
			chk("pd_idle", power_down_n_out, 1'b1);
		end
		bus_wr(FUNC_CTRL_OFFSET, 8'h40, r);
		for (int p = 0; p < 2; p++) begin
			@(posedge clk_in);
			wait_pwr_pin_in <= p[0];
			settle();
			chk("pd_pin", power_down_n_out, p[0]);
			chk("zw_off", zero_wait_oe_out, 1'b0);
		end
		bus_wr(FUNC_CTRL_OFFSET, 8'h00, r);
	endtask

	// Every port mode against strobe and extra write protect
	task automatic t_port;
		logic [1:0] r;
		for (int m = 0; m < 8; m++) begin
			bus_wr(PORT_MODE_OFFSET, m[7:0], r);
			for (int v = 0; v < 2; v++) begin
				@(posedge clk_in);
				epp_strobe_req_in <= v[0];
				spp_strobe_n_in <= v[0];
				floppy_wp_pin_in <= v[0];
				settle();
				chk("strobe", strobe_pin_n_out, m[0] ? !v[0] : v[0]);
				chk("wp", floppy_wp_extra_out, m[1] && !m[2] && v[0]);
			end
		end
	endtask

	// One placement and enable setting with one transmit level
	task automatic t_place(input logic [1:0] loc, input logic en, tx);
		logic       act;
		logic [1:0] r;
		act = loc == 2'h3 || (en && loc != 2'h0);
		bus_wr(IR_CFG_OFFSET, {4'h0, loc, 1'b0, en}
			| (loc == 2'h3 ? 8'hf2 : 8'h00), r);
		@(posedge clk_in);
		cur_loc <= loc;
		ir_encoder_tx_in <= tx;
		ir_send <= !tx;
		settle();
		chk("tx2", port2_tx_pin_out, act);
		chk("dtr", port2_terminal_pin_out, loc == 2'h1 ? en && tx : 1'b1);
		chk("modem", port2_modem_int_out,
			act ? 4'b1010 : {3'b010, loc != 2'h1 && !tx});
		chk("rx", ir_decoder_rx_out, act && loc != 2'h2 ? !tx : 1'b1);
		chk("hi", drive_high_byte_pin_out, loc[1] ? act && tx : 1'b1);
		chk("ack", drive_dma_acknowledge_out, loc == 2'h3 || !tx);
		if (act)
			chk("xcvr", tx_seen, tx);
		if (loc != 2'h2)
			chk("ident", {drive_ident_out, drive_16bit_select_out,
				drive_status_valid_out}, loc == 2'h3 ? 4'h0 : 4'hb);
	endtask

	// Baud clock output escapes the forced high level
	task automatic t_baud;
		@(posedge clk_in);
		port2_baud_sel_in <= 1'b1;
		settle();
		chk("bout", port2_tx_pin_out, 1'b0);
		@(posedge clk_in);
		port2_baud_sel_in <= 1'b0;
	endtask

	// Main sequence
	initial begin
		rst_n_in = 1'b0;
		{awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 5'h00;
		{awaddr_in, araddr_in, wdata_in, wstrb_in} = {8'h00, 32'h0, 4'hf};
		{wait_pwr_pin_in, epp_write_in, cycle_short_ok_in} = 3'h0;
		{epp_strobe_req_in, spp_strobe_n_in, floppy_wp_pin_in} = 3'h2;
		{port2_serial_output_in, port2_baud_clock_out_in} = 2'h0;
		{port2_baud_sel_in, port2_terminal_ready_in, ir_encoder_tx_in} = 3'h2;
		{drive_high_byte_enable_in, drive_16bit_pin_in} = 2'h3;
		drive_ident_pins_in = 2'h2;
		{ir_send, cur_loc} = 3'h4;
		repeat (2) @(posedge clk_in);
		rst_n_in <= 1'b1;
		#1;
		chk("rst", {zero_wait_oe_out, power_down_n_out, ir_decoder_rx_out,
			drive_dma_acknowledge_out, drive_status_valid_out,
			port2_tx_pin_out, awready_out, rvalid_out}, 8'h74);
		t_regs();
		t_wait();
		t_port();
		for (int k = 0; k < 16; k++)
			t_place(k[3:2], k[1], k[0]);
		t_baud();
		give_verdict();
	end
endmodule
